// File: audio_transmitter.sv
`timescale 1ns/100ps
module audio_transmitter
    import audio_tx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Processor register port
    input wire logic [15:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regWrData,
    output logic [DATA_W-1:0] regRdData,
    // Interrupt request
    output logic irqRequest,
    // Link pins
    input wire logic ext_clock_pin,
    output logic serial_audio_out
);
    tx_state_e state_r;
    tx_state_e state_nxt;

    logic ctrlEn_r;
    logic ctrlIen_r;
    logic ctrlStp_r;
    logic [1:0] ctrlCs_r;
    logic [NA_W-1:0] nonAudioA_r;
    logic [NA_W-1:0] nonAudioB_r;

    logic [DATA_W-1:0] chanAHolding_r;
    logic [DATA_W-1:0] chanBHolding_r;
    logic [DATA_W-1:0] chanBAudioBuffer_r;
    logic [NA_W-1:0] chanBNonaudioBuffer_r;
    logic [SHIFT_W-1:0] subframeShifter_r;
    logic [SHIFT_W-1:0] shifter_nxt;

    logic writeToB_r;
    logic audioEmptyFlag_r;
    logic underrunFlag_r;
    logic underrunArmed_r;
    logic blockFlag_r;
    logic [HC_W-1:0] halfCell_r;
    logic [7:0] frameCount_r;
    logic lineLevel_r;
    logic polarity_r;
    logic parity_r;
    logic [DATA_W-1:0] rdData_r;

    wire tick;
    wire running;
    wire idle;
    wire ctrlWrite;
    wire audioWrite;
    wire writeA;
    wire writeB;
    wire statRead;
    wire startTx;
    wire frameEnd;
    wire stopDeferred;
    wire stopNow;
    wire stopAny;
    wire advance;
    wire [HC_W-1:0] halfCellNxt;
    wire [4:0] slotNxt;
    wire secondHalf;
    wire subframeB;
    wire subStart;
    wire upload;
    wire loadB;
    wire inPreamble;
    wire shiftNow;
    wire parityAccum;
    wire dataBit;
    wire [7:0] frameNxt;
    wire [7:0] frameShown;
    wire [7:0] preamble;
    wire preBit;
    wire polarityNow;
    wire levelNxt;
    wire [DATA_W-1:0] ctrlView;
    wire [DATA_W-1:0] statView;
    wire [DATA_W-1:0] readMux;

    half_cell_ticker u_ticker (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clockSelect(ctrlCs_r),
        .run(running),
        .extClockPin(ext_clock_pin),
        .tick(tick)
    );

    // Register decode
    assign ctrlWrite = regWrite & (regAddr == ADDR_CTRL);
    assign audioWrite = regWrite & (regAddr == ADDR_AUDIO);
    assign writeA = audioWrite & ~writeToB_r;
    assign writeB = audioWrite & writeToB_r;
    assign statRead = regRead & (regAddr == ADDR_STAT);

    // Run control
    assign running = (state_r == ST_RUN);
    assign idle = (state_r == ST_IDLE);
    assign startTx = idle & ctrlEn_r;
    assign frameEnd = running & tick & (halfCell_r == HC_LAST);
    assign stopDeferred = frameEnd & ~ctrlEn_r & ctrlStp_r;
    assign stopNow = running & ~ctrlEn_r & ~ctrlStp_r;
    assign stopAny = stopDeferred | stopNow;
    assign advance = startTx | (running & tick & ~stopAny);
    assign state_nxt = startTx ? ST_RUN : stopAny ? ST_IDLE : state_r;

    // Position of the half-cell being entered
    assign halfCellNxt = startTx ? HC_FIRST : halfCell_r + HC_STEP;
    assign slotNxt = halfCellNxt[5:1];
    assign secondHalf = halfCellNxt[0];
    assign subframeB = halfCellNxt[HC_SUB_BIT];
    assign subStart = (halfCellNxt[5:0] == HC_SUB_START);
    assign upload = advance & (halfCellNxt == HC_FIRST);
    assign loadB = advance & (halfCellNxt == HC_CHB);
    assign inPreamble = (slotNxt < SLOT_DATA_FIRST);
    assign shiftNow = advance & ~secondHalf & (slotNxt >= SLOT_SHIFT_FIRST);
    assign parityAccum = advance & secondHalf & ~inPreamble & (slotNxt != SLOT_PARITY);

    // Block position
    assign frameNxt = (startTx | (frameCount_r == FRAME_LAST)) ? FRAME_FIRST
                      : frameCount_r + FRAME_STEP;
    assign frameShown = upload ? frameNxt : frameCount_r;

    // Line coding
    assign dataBit = (slotNxt == SLOT_PARITY) ? parity_r : subframeShifter_r[0];
    assign preamble = subframeB ? PRE_Y :
                      (frameShown == FRAME_FIRST) ? PRE_Z : PRE_X;
    assign preBit = preamble[PRE_MSB - halfCellNxt[2:0]];
    // Preamble polarity follows the level left by the previous sub-frame
    assign polarityNow = subStart ? lineLevel_r : polarity_r;
    assign levelNxt = inPreamble ? (polarityNow ? preBit : ~preBit) :
                      ~secondHalf ? ~lineLevel_r :
                      (lineLevel_r ^ dataBit);

    // Shifter load and shift
    assign shifter_nxt = upload ? {nonAudioA_r, chanAHolding_r} :
                         loadB ? {chanBNonaudioBuffer_r, chanBAudioBuffer_r} :
                         shiftNow ? {1'b0, subframeShifter_r[SHIFT_W-1:1]} :
                         subframeShifter_r;

    // Register read views
    assign ctrlView[CTRL_EN] = ctrlEn_r;
    assign ctrlView[CTRL_IEN] = ctrlIen_r;
    assign ctrlView[CTRL_STP] = ctrlStp_r;
    assign ctrlView[CTRL_CS_HI:CTRL_CS_LO] = ctrlCs_r;
    assign ctrlView[CTRL_RSVA_HI:CTRL_RSVA_LO] = '0;
    assign ctrlView[CTRL_NAA_HI:CTRL_NAA_LO] = nonAudioA_r;
    assign ctrlView[CTRL_NAB_HI:CTRL_NAB_LO] = nonAudioB_r;
    assign ctrlView[CTRL_RSVB_HI:CTRL_RSVB_LO] = '0;
    assign statView[STAT_EMPTY] = audioEmptyFlag_r;
    assign statView[STAT_RSVA] = 1'b0;
    assign statView[STAT_UNDERRUN] = underrunFlag_r;
    assign statView[STAT_BLOCK] = blockFlag_r;
    assign statView[STAT_TIP] = running;
    assign statView[STAT_RSV_HI:STAT_RSV_LO] = '0;
    assign readMux = (regAddr == ADDR_CTRL) ? ctrlView :
                     (regAddr == ADDR_STAT) ? statView : '0;

    assign regRdData = rdData_r;
    assign irqRequest = ctrlIen_r & audioEmptyFlag_r;
    assign serial_audio_out = lineLevel_r;

    // Configuration bits; the non-audio bits carry no reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrlEn_r <= 1'b0;
            ctrlIen_r <= 1'b0;
            ctrlStp_r <= 1'b0;
            ctrlCs_r <= CS_CORE;
        end else if (ctrlWrite) begin
            ctrlEn_r <= regWrData[CTRL_EN];
            ctrlIen_r <= regWrData[CTRL_IEN];
            ctrlStp_r <= regWrData[CTRL_STP];
            ctrlCs_r <= regWrData[CTRL_CS_HI:CTRL_CS_LO];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ctrlWrite) begin
            nonAudioA_r <= regWrData[CTRL_NAA_HI:CTRL_NAA_LO];
            nonAudioB_r <= regWrData[CTRL_NAB_HI:CTRL_NAB_LO];
        end
    end

    // Holding words and the channel B buffers; old contents stay for resend
    always_ff @(posedge sys_clk) begin
        if (writeA) begin
            chanAHolding_r <= regWrData;
        end
        if (writeB) begin
            chanBHolding_r <= regWrData;
        end
        if (upload) begin
            chanBAudioBuffer_r <= chanBHolding_r;
            chanBNonaudioBuffer_r <= nonAudioB_r;
        end
        subframeShifter_r <= shifter_nxt;
    end

    // Write pointer: the frame start wins over a write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst | stopAny | upload) begin
            writeToB_r <= 1'b0;
        end else if (audioWrite) begin
            writeToB_r <= ~writeToB_r;
        end
    end

    // Status flags; an upload in the cycle of a clearing write wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst | stopAny) begin
            audioEmptyFlag_r <= 1'b0;
            underrunFlag_r <= 1'b0;
            underrunArmed_r <= 1'b0;
            blockFlag_r <= 1'b0;
        end else begin
            if (upload) begin
                audioEmptyFlag_r <= 1'b1;
            end else if (writeB) begin
                audioEmptyFlag_r <= 1'b0;
            end
            if (upload & audioEmptyFlag_r) begin
                underrunFlag_r <= 1'b1;
            end else if (writeB & underrunArmed_r) begin
                underrunFlag_r <= 1'b0;
            end
            if (writeB) begin
                underrunArmed_r <= 1'b0;
            end else if (statRead & underrunFlag_r) begin
                underrunArmed_r <= 1'b1;
            end
            if (upload & (frameNxt == FRAME_LAST)) begin
                blockFlag_r <= 1'b1;
            end else if (writeB) begin
                blockFlag_r <= 1'b0;
            end
        end
    end

    // Frame sequencer and line state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            halfCell_r <= HC_FIRST;
            frameCount_r <= FRAME_FIRST;
            lineLevel_r <= 1'b1;
            polarity_r <= 1'b1;
            parity_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (stopAny) begin
                halfCell_r <= HC_FIRST;
                lineLevel_r <= 1'b1;
                parity_r <= 1'b0;
            end else if (advance) begin
                halfCell_r <= halfCellNxt;
                lineLevel_r <= levelNxt;
                if (subStart) begin
                    polarity_r <= lineLevel_r;
                    parity_r <= 1'b0;
                end else if (parityAccum) begin
                    parity_r <= parity_r ^ subframeShifter_r[0];
                end
            end
            if (upload) begin
                frameCount_r <= frameNxt;
            end
        end
    end

    // Registered read data; the audio address reads zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData_r <= '0;
        end else if (regRead) begin
            rdData_r <= readMux;
        end
    end
endmodule

// File: audio_tx_pkg.sv
package audio_tx_pkg;

    // Word addresses on the processor I/O port
    localparam logic [15:0] ADDR_AUDIO = 16'hFFDD;
    localparam logic [15:0] ADDR_CTRL = 16'hFFDE;
    localparam logic [15:0] ADDR_STAT = 16'hFFDF;

    localparam int DATA_W = 24;
    localparam int NA_W = 3;
    localparam int SHIFT_W = 27;

    // Control register layout
    localparam int CTRL_EN = 0;
    localparam int CTRL_IEN = 1;
    localparam int CTRL_STP = 2;
    localparam int CTRL_CS_LO = 3;
    localparam int CTRL_CS_HI = 4;
    localparam int CTRL_RSVA_LO = 5;
    localparam int CTRL_RSVA_HI = 9;
    localparam int CTRL_NAA_LO = 10;
    localparam int CTRL_NAA_HI = 12;
    localparam int CTRL_NAB_LO = 13;
    localparam int CTRL_NAB_HI = 15;
    localparam int CTRL_RSVB_LO = 16;
    localparam int CTRL_RSVB_HI = 23;

    // Status register layout
    localparam int STAT_EMPTY = 0;
    localparam int STAT_RSVA = 1;
    localparam int STAT_UNDERRUN = 2;
    localparam int STAT_BLOCK = 3;
    localparam int STAT_TIP = 4;
    localparam int STAT_RSV_LO = 5;
    localparam int STAT_RSV_HI = 23;

    // Clock select codes
    localparam logic [1:0] CS_CORE = 2'h0;
    localparam logic [1:0] CS_EXT256 = 2'h1;
    localparam logic [1:0] CS_EXT384 = 2'h2;
    localparam logic [1:0] CS_EXT512 = 2'h3;

    // Source rates as multiples of the sample rate; the half-cell rate is 128 fs
    localparam int CLK_HZ = 10000000;
    localparam int CORE_FS_RATIO = 1024;
    localparam int EXT256_FS_RATIO = 256;
    localparam int EXT384_FS_RATIO = 384;
    localparam int EXT512_FS_RATIO = 512;
    localparam int HALF_CELL_FS_RATIO = 128;
    localparam logic [2:0] DIV_CORE = 3'(CORE_FS_RATIO / HALF_CELL_FS_RATIO);
    localparam logic [2:0] DIV_EXT256 = 3'(EXT256_FS_RATIO / HALF_CELL_FS_RATIO);
    localparam logic [2:0] DIV_EXT384 = 3'(EXT384_FS_RATIO / HALF_CELL_FS_RATIO);
    localparam logic [2:0] DIV_EXT512 = 3'(EXT512_FS_RATIO / HALF_CELL_FS_RATIO);

    // Frame timing in half-cells: 2 sub-frames of 32 slots of 2 halves
    localparam int HC_W = 7;
    localparam logic [HC_W-1:0] HC_FIRST = 7'h00;
    localparam logic [HC_W-1:0] HC_LAST = 7'h7F;
    localparam logic [HC_W-1:0] HC_CHB = 7'h40;
    localparam logic [HC_W-1:0] HC_STEP = 7'h01;
    localparam int HC_SUB_BIT = 6;
    localparam logic [5:0] HC_SUB_START = 6'h00;
    localparam logic [4:0] SLOT_DATA_FIRST = 5'h04;
    localparam logic [4:0] SLOT_SHIFT_FIRST = 5'h05;
    localparam logic [4:0] SLOT_PARITY = 5'h1F;
    localparam logic [2:0] PRE_MSB = 3'h7;

    // Preambles, sent most significant bit first
    localparam logic [7:0] PRE_X = 8'h1D;
    localparam logic [7:0] PRE_Y = 8'h1B;
    localparam logic [7:0] PRE_Z = 8'h17;

    localparam logic [7:0] FRAME_FIRST = 8'h00;
    localparam logic [7:0] FRAME_LAST = 8'hBF;
    localparam logic [7:0] FRAME_STEP = 8'h01;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } tx_state_e;

endpackage

// File: half_cell_ticker.sv
`timescale 1ns/100ps
module half_cell_ticker
    import audio_tx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Source selection
    input wire logic [1:0] clockSelect,
    input wire logic run,
    input wire logic extClockPin,
    // Half-cell strobe
    output logic tick
);
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic extLevel_r;
    logic extPrev_r;
    logic [2:0] count_r;
    logic [2:0] count_nxt;
    wire extRise;
    wire srcEvent;
    wire [2:0] divide;
    wire atTerminal;

    // Pin edges count only after two stages agree; pin must stay below a quarter of sys_clk
    assign extRise = extLevel_r & ~extPrev_r;
    assign srcEvent = (clockSelect == CS_CORE) ? 1'b1 : extRise;
    assign divide = (clockSelect == CS_CORE) ? DIV_CORE :
                    (clockSelect == CS_EXT256) ? DIV_EXT256 :
                    (clockSelect == CS_EXT384) ? DIV_EXT384 : DIV_EXT512;
    assign atTerminal = (count_r == divide - 3'h1);
    assign tick = run & srcEvent & atTerminal;
    assign count_nxt = ~run ? 3'h0 : ~srcEvent ? count_r : atTerminal ? 3'h0 : count_r + 3'h1;

    always_ff @(posedge sys_clk) begin
        sync1_r <= extClockPin;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            extLevel_r <= 1'b0;
            extPrev_r <= 1'b0;
            count_r <= 3'h0;
        end else begin
            if (sync2_r == sync3_r) begin
                extLevel_r <= sync3_r;
            end
            extPrev_r <= extLevel_r;
            count_r <= count_nxt;
        end
    end
endmodule

// File: audio_transmitter_assertions.sv
`timescale 1ns/100ps
module audio_transmitter_checker
    import audio_tx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic [DATA_W-1:0] regRdData,
    // Request and link
    input wire logic irqRequest,
    input wire logic ext_clock_pin,
    input wire logic serial_audio_out
);
    logic en_r;
    logic ien_r;
    logic stp_r;
    logic [1:0] cs_r;
    wire ctrlWr = regWrite && regAddr == ADDR_CTRL;
    // Shadow of the control bits, so outputs can be tied to what was written
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {cs_r, stp_r, ien_r, en_r} <= 5'h00;
        end else if (ctrlWr) begin
            {cs_r, stp_r, ien_r, en_r} <= regWrData[4:0];
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    AST_RST_QUIET: assert property ($past(sys_rst) |-> serial_audio_out && !irqRequest)
        else $error("line or request active after reset");
    AST_CTRL_RSV: assert property (regRead && regAddr == ADDR_CTRL |=>
        regRdData[9:5] == 5'h00 && regRdData[23:16] == 8'h00)
        else $error("reserved control bits read nonzero");
    AST_STAT_RSV: assert property (regRead && regAddr == ADDR_STAT |=>
        !regRdData[1] && regRdData[23:5] == 19'h00000)
        else $error("reserved status bits read nonzero");
    AST_AUDIO_WO: assert property (regRead && regAddr == ADDR_AUDIO |=> regRdData == 24'h0)
        else $error("audio address readable");
    AST_CTRL_BACK: assert property (regRead && !regWrite && regAddr == ADDR_CTRL |=>
        regRdData[4:0] == {cs_r, stp_r, ien_r, en_r})
        else $error("control bits read back wrong");
    AST_IRQ_MASK: assert property (irqRequest |-> ien_r)
        else $error("request raised while masked");
    AST_IRQ_UPLOAD: assert property ($rose(en_r) && ien_r |-> ##[1:4] irqRequest)
        else $error("no request after first upload");
    AST_START_PRE: assert property ($rose(en_r) && cs_r == CS_CORE |->
        ##[1:3] (!serial_audio_out [*8]))
        else $error("preamble did not open low");
    AST_IDLE_HIGH: assert property ((!en_r && !stp_r) [*3] |-> serial_audio_out)
        else $error("line not high after immediate stop");
    // Only the lower bound is checked: a missed tick shows up in the frame length
    AST_HALF_CELL: assert property ($changed(serial_audio_out) && en_r && cs_r == CS_CORE |=>
        ($stable(serial_audio_out) [*7]) or (##[0:7] !en_r))
        else $error("half cell shorter than eight clocks");
endmodule

bind audio_transmitter audio_transmitter_checker i_chk (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWrite(regWrite),
    .regRead(regRead),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .irqRequest(irqRequest),
    .ext_clock_pin(ext_clock_pin),
    .serial_audio_out(serial_audio_out)
);

// File: audio_rx_model.sv
`timescale 1ns/100ps
module audio_rx_model (
    // Clock and line
    input wire logic sys_clk,
    input wire logic serialIn,
    input wire logic capture,
    // Clock source for the pin
    output logic extClock,
    // Last decoded frame and running counts
    output logic [127:0] levels,
    output logic [63:0] slotBits,
    output int badCells,
    output int frames
);
    logic [127:0] lv;
    initial begin
        extClock = 1'h0;
        forever begin
            // 800 ns period keeps below the pin limit
            repeat (4) @(negedge sys_clk);
            extClock = ~extClock;
        end
    end
    initial begin
        frames = 0;
        badCells = 0;
        levels = 128'h0;
        forever begin
            @(posedge capture);
            // Sample mid half-cell on the falling edge, away from the level change
            repeat (8) @(negedge sys_clk);
            while (capture) begin
                for (int i = 0; i < 128; i++) begin
                    lv[127 - i] = serialIn;
                    repeat (8) @(negedge sys_clk);
                end
                for (int s = 0; s < 64; s++) begin
                    slotBits[s] = lv[127 - 2 * s] ^ lv[126 - 2 * s];
                    if (s % 32 >= 4 && lv[127 - 2 * s] == lv[128 - 2 * s]) begin
                        badCells++;
                    end
                end
                levels = lv;
                frames++;
            end
        end
    end
endmodule

// File: audio_transmitter_tb.sv
`timescale 1ns/100ps
module audio_transmitter_tb
    import audio_tx_pkg::*;
;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [15:0] regAddr = 16'h0000;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic capture = 1'h0;
    logic [DATA_W-1:0] regWrData = 24'h000000;
    logic [DATA_W-1:0] regRdData;
    logic [DATA_W-1:0] rd;
    logic irqRequest;
    logic extClock;
    logic serialOut;
    logic [127:0] levels;
    logic [63:0] slotBits;
    int badCells;
    int frames;
    int error_cnt = 0;
    int comparisons = 0;

    initial forever #50 sys_clk = ~sys_clk;

    audio_transmitter i_dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .regAddr(regAddr),
        .regWrite(regWrite),
        .regRead(regRead),
        .regWrData(regWrData),
        .regRdData(regRdData),
        .irqRequest(irqRequest),
        .ext_clock_pin(extClock),
        .serial_audio_out(serialOut)
    );
    audio_rx_model i_rx (
        .sys_clk(sys_clk),
        .serialIn(serialOut),
        .capture(capture),
        .extClock(extClock),
        .levels(levels),
        .slotBits(slotBits),
        .badCells(badCells),
        .frames(frames)
    );

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [DATA_W-1:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'h1;
        @(negedge sys_clk);
        regWrite = 1'h0;
    endtask

    task automatic rdReg(input logic [15:0] a);
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'h1;
        @(negedge sys_clk);
        regRead = 1'h0;
        rd = regRdData;
    endtask

    task automatic checkFrame(input int n, input logic [23:0] a, input logic [23:0] b,
            input logic [2:0] na, input logic [2:0] nb, input logic [7:0] preA);
        for (int i = 0; i < 1100 && frames < n; i++) @(posedge sys_clk);
        repeat (4) @(negedge sys_clk);
        check("frame count", frames, n);
        check("preamble A", levels[127:120], preA);
        check("preamble B", levels[63:56], PRE_Y);
        check("slots A", slotBits[31:4], {^{na, a}, na, a});
        check("slots B", slotBits[63:36], {^{nb, b}, nb, b});
        check("cell edges", badCells, 0);
    endtask

    task automatic t_reset_regs;
        rdReg(ADDR_CTRL);
        // Non-audio bits carry no reset and are unknown until written
        check("ctrl reset", {rd[23:16], rd[9:0]}, 18'h00000);
        wr(16'hFF00, 24'hFFFFFF);
        rdReg(16'hFF00);
        check("unmapped", rd, 24'h000000);
        wr(ADDR_CTRL, 24'hFFFFFF);
        rdReg(ADDR_CTRL);
        check("ctrl reserved", rd, 24'h00FC1F);
        rdReg(ADDR_AUDIO);
        check("audio read", rd, 24'h000000);
        sys_rst = 1'h1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'h0;
        rdReg(ADDR_CTRL);
        check("ctrl after reset", rd, 24'h00FC00);
        rdReg(ADDR_STAT);
        check("status after reset", rd, 24'h000000);
        check("line after reset", serialOut, 1'h1);
    endtask

    task automatic t_frames;
        wr(ADDR_CTRL, 24'h007402);
        wr(ADDR_AUDIO, 24'hA5C3E1);
        wr(ADDR_AUDIO, 24'h3C0F96);
        capture = 1'h1;
        wr(ADDR_CTRL, 24'h007403);
        repeat (6) @(negedge sys_clk);
        rdReg(ADDR_STAT);
        check("status at start", rd[4:0], 5'h11);
        check("irq at start", irqRequest, 1'h1);
        checkFrame(1, 24'hA5C3E1, 24'h3C0F96, 3'h5, 3'h3, PRE_Z);
        rdReg(ADDR_STAT);
        check("underrun", rd[4:0], 5'h15);
        wr(ADDR_AUDIO, 24'h0F0F0F);
        wr(ADDR_AUDIO, 24'h800001);
        wr(ADDR_AUDIO, 24'hFFFFFE);
        check("irq after B", irqRequest, 1'h0);
        checkFrame(2, 24'hA5C3E1, 24'h3C0F96, 3'h5, 3'h3, PRE_X);
        rdReg(ADDR_STAT);
        check("underrun cleared", rd[4:0], 5'h11);
        wr(ADDR_CTRL, 24'h008803);
        wr(ADDR_AUDIO, 24'h123456);
        wr(ADDR_AUDIO, 24'h654321);
        rdReg(ADDR_STAT);
        check("empty cleared", rd[STAT_EMPTY], 1'h0);
        checkFrame(3, 24'hFFFFFE, 24'h800001, 3'h5, 3'h3, PRE_X);
        checkFrame(4, 24'h123456, 24'h654321, 3'h2, 3'h4, PRE_X);
    endtask

    task automatic t_stops;
        capture = 1'h0;
        wr(ADDR_CTRL, 24'h008804);
        // Well inside the frame: an early halt shows here
        repeat (880) @(negedge sys_clk);
        rdReg(ADDR_STAT);
        check("deferred running", rd[STAT_TIP], 1'h1);
        for (int i = 0; i < 200 && rd[STAT_TIP] !== 1'h0; i++) rdReg(ADDR_STAT);
        check("deferred stopped", rd[STAT_TIP], 1'h0);
        check("line deferred", serialOut, 1'h1);
        wr(ADDR_CTRL, 24'h008801);
        repeat (50) @(negedge sys_clk);
        wr(ADDR_CTRL, 24'h008800);
        repeat (2) @(negedge sys_clk);
        check("line stopped", serialOut, 1'h1);
        rdReg(ADDR_STAT);
        check("status stopped", rd, 24'h000000);
    endtask

    task automatic t_clock_sel;
        int ratio [4] = '{1024, 256, 384, 512};
        int per [4] = '{1, 8, 8, 8};
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CTRL, 24'(c << CTRL_CS_LO));
            wr(ADDR_CTRL, 24'(c << CTRL_CS_LO) | 24'h000001);
            wr(ADDR_AUDIO, 24'h000001);
            wr(ADDR_AUDIO, 24'h000002);
            n = 4;
            rd = 24'h000000;
            while (n < 5000 && rd[STAT_EMPTY] !== 1'h1) begin
                rdReg(ADDR_STAT);
                n += 2;
            end
            // Frame spans ratio source clocks; slack covers pin sync and polling
            check("frame length", (n - ratio[c] * per[c]) / 30, 0);
            wr(ADDR_CTRL, 24'(c << CTRL_CS_LO));
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #4000000;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'h0;
        t_reset_regs();
        t_frames();
        t_stops();
        t_clock_sel();
        summarize();
    end
endmodule
